/* File: acs_pkg.sv */
// constants, register map and state codes of the converter sequencer
package acs_pkg;

  localparam int RES_W = 10;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int REG_W = 8;

  // register byte addresses
  localparam logic [11:0] OFF_CTRL0 = 12'h000;
  localparam logic [11:0] OFF_CTRL2 = 12'h004;
  localparam logic [11:0] OFF_CFG = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00c;
  localparam logic [11:0] OFF_RESH = 12'h010;
  localparam logic [11:0] OFF_RESL = 12'h014;

  // converter_control_zero fields
  localparam int CTRL0_EN = 0;
  localparam int CTRL0_RUN = 1;
  localparam int CTRL0_CHS_LSB = 2;
  localparam int CHS_W = 5;
  localparam logic [7:0] CTRL0_RST = 8'h00;

  // converter_control_two fields
  localparam int CTRL2_TRIG_LSB = 0;
  localparam int TRIG_W = 3;
  localparam logic [2:0] TRIG_RST = 3'h0;
  localparam logic [2:0] TRIG_NONE = 3'h0;
  localparam logic [2:0] TRIG_TIMER_ZERO_EVENT = 3'h1;
  localparam logic [2:0] TRIG_TIMER_ONE_EVENT = 3'h2;
  localparam logic [2:0] TRIG_TIMER_TWO_EVENT = 3'h3;
  localparam logic [2:0] TRIG_CMP1 = 3'h4;
  localparam logic [2:0] TRIG_CMP2 = 3'h5;

  // converter config fields: conversion clock select and interrupt enable
  localparam int CFG_CLK_LSB = 0;
  localparam int CLK_W = 3;
  localparam int CFG_IE = 3;
  localparam logic [2:0] CLK_RST = 3'h0;
  localparam logic [2:0] CLK_FRC_MASK = 3'h3;

  // status fields
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_PWR = 2;

  // system clock cycles in one instruction cycle
  localparam int INSTR_CYCLES = 4;
  localparam int DIV_W = 7;

  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_DELAY = 2'b01,
    ACS_CONV = 2'b10
  } acs_state_t;

endpackage

/* File: acs_sar_engine.sv */
// successive approximation bit engine with partial result fill
`timescale 1ns/1ns
module acs_sar_engine (
  input wire logic pclk,
  input wire logic presetn,
  acs_sar_if.engine sif
);
  import acs_pkg::*;

  typedef struct packed {
    logic active;
    logic sampled;
    logic any;
    logic last;
    logic done;
    logic [3:0] idx;
    logic [RES_W-1:0] code;
  } acs_sar_state_t;

  acs_sar_state_t r_reg;
  acs_sar_state_t r_next;

  // unresolved bits copy the most recently resolved bit
  function automatic logic [RES_W-1:0] fill_partial(
    input logic [RES_W-1:0] code,
    input logic [3:0] idx,
    input logic last,
    input logic any
  );
    logic [RES_W-1:0] res;
    res = code;
    for (int i = 0; i < RES_W; i++) begin
      if (i <= int'(idx)) begin
        res[i] = any & last;
      end
    end
    return res;
  endfunction

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (sif.start) begin
      r_next.active = 1'b1;
      r_next.sampled = 1'b0;
      r_next.any = 1'b0;
      r_next.last = 1'b0;
      r_next.idx = 4'(RES_W - 1);
      r_next.code = '0;
      r_next.code[RES_W-1] = 1'b1;
    end else if (sif.abort) begin
      r_next.active = 1'b0;
    end else if (r_reg.active && sif.tad_tick) begin
      if (!r_reg.sampled) begin
        // first period hands the sample to the hold capacitor
        r_next.sampled = 1'b1;
      end else begin
        r_next.code[r_reg.idx] = sif.cmp;
        r_next.last = sif.cmp;
        r_next.any = 1'b1;
        if (r_reg.idx == 4'h0) begin
          r_next.active = 1'b0;
          r_next.done = 1'b1;
        end else begin
          r_next.idx = r_reg.idx - 4'h1;
          r_next.code[r_reg.idx - 4'h1] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sif.busy = r_reg.active;
  assign sif.done = r_reg.done;
  assign sif.result = r_reg.code;
  assign sif.dac_code = r_reg.code;
  assign sif.partial = fill_partial(r_reg.code, r_reg.idx, r_reg.last, r_reg.any);
endmodule

/* File: acs_sar_if.sv */
// handshake between sequencer control and successive approximation engine
`timescale 1ns/1ns
interface acs_sar_if;
  import acs_pkg::*;
  logic start;
  logic abort;
  logic tad_tick;
  logic cmp;
  logic busy;
  logic done;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] partial;
  logic [RES_W-1:0] dac_code;

  modport ctrl (
    output start, abort, tad_tick, cmp,
    input busy, done, result, partial, dac_code
  );

  modport engine (
    input start, abort, tad_tick, cmp,
    output busy, done, result, partial, dac_code
  );
endinterface

/* File: acs_top.sv */
// converter sequencer: apb registers, start, trigger, sleep and completion control
//
// Function
// - converter works only while enable bit set
// - writing run bit high starts conversion
// - completion clears run, sets done, loads result
// - clearing run early aborts, loads partial result
// - unresolved bits copy last resolved bit
// - reset clears registers, stops any conversion
// - only rc clock keeps converting in sleep
// - rc clock delays start one instruction cycle
// - done in sleep with interrupt wakes device
// - sleep without interrupt powers off after done
// - sleep on system clock aborts, powers off
// - rising trigger edge sets run bit
// - three bit field selects trigger source
// - control zero bit 7 reads zero, resets zero
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
module acs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [acs_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acs_pkg::APB_DW-1:0] pwdata,
  output logic [acs_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_active,
  input wire logic timer_zero_event,
  input wire logic timer_one_event,
  input wire logic timer_two_event,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  input wire logic frc_clock_in,
  input wire logic sar_comparator_in,
  output logic converter_powered,
  output logic sample_hold_en,
  output logic [acs_pkg::CHS_W-1:0] channel_select,
  output logic [acs_pkg::RES_W-1:0] sar_dac_code,
  output logic conversion_done_flag,
  output logic wake_request
);
  import acs_pkg::*;

  typedef struct packed {
    acs_state_t state;
    logic enable;
    logic run;
    logic [CHS_W-1:0] chan;
    logic [TRIG_W-1:0] trig;
    logic [CLK_W-1:0] clksel;
    logic ie;
    logic done;
    logic [RES_W-1:0] result;
    logic powered_down;
    logic [DIV_W-2:0] div_cnt;
    logic [1:0] delay_cnt;
    logic [REG_W-1:0] rdata;
    logic [4:0] trg_s1;
    logic [4:0] trg_s2;
    logic [4:0] trg_s3;
    logic frc_s1;
    logic frc_s2;
    logic frc_s3;
    logic cmp_s1;
    logic cmp_s2;
    logic wake;
  } acs_top_state_t;

  acs_top_state_t r_reg;
  acs_top_state_t r_next;

  acs_sar_if sif ();

  logic start_pulse;
  logic abort_pulse;
  logic tad_tick;

  // system clock division for each conversion clock code
  function automatic logic [DIV_W-1:0] div_of(input logic [CLK_W-1:0] sel);
    logic [DIV_W-1:0] d;
    case (sel)
      3'h0: d = 7'h02;
      3'h4: d = 7'h04;
      3'h1: d = 7'h08;
      3'h5: d = 7'h10;
      3'h2: d = 7'h20;
      3'h6: d = 7'h40;
      default: d = 7'h02;
    endcase
    return d;
  endfunction

  function automatic logic addr_ok(input logic [APB_AW-1:0] a);
    logic ok;
    case (a)
      OFF_CTRL0, OFF_CTRL2, OFF_CFG, OFF_STAT, OFF_RESH, OFF_RESL: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic is_frc(input logic [CLK_W-1:0] sel);
    return (sel & CLK_FRC_MASK) == CLK_FRC_MASK;
  endfunction

  always_comb begin
    logic setup;
    logic wr;
    logic frc_sel;
    logic sys_tick;
    logic frc_tick;
    logic trig_edge;
    logic start_req;
    logic sw_abort;
    logic kill;
    logic [4:0] edges;
    setup = 1'b0;
    wr = 1'b0;
    frc_sel = 1'b0;
    sys_tick = 1'b0;
    frc_tick = 1'b0;
    trig_edge = 1'b0;
    start_req = 1'b0;
    sw_abort = 1'b0;
    kill = 1'b0;
    edges = '0;
    r_next = r_reg;
    r_next.wake = 1'b0;
    start_pulse = 1'b0;
    abort_pulse = 1'b0;

    // pin synchronisers; the third stage feeds edge detection
    r_next.trg_s1 = {comparator_two_output, comparator_one_output, timer_two_event,
                     timer_one_event, timer_zero_event};
    r_next.trg_s2 = r_reg.trg_s1;
    r_next.trg_s3 = r_reg.trg_s2;
    r_next.frc_s1 = frc_clock_in;
    r_next.frc_s2 = r_reg.frc_s1;
    r_next.frc_s3 = r_reg.frc_s2;
    r_next.cmp_s1 = sar_comparator_in;
    r_next.cmp_s2 = r_reg.cmp_s1;

    // conversion clock: system divider ticks are masked in sleep, rc clock keeps running
    frc_sel = is_frc(r_reg.clksel);
    frc_tick = r_reg.frc_s2 & ~r_reg.frc_s3;
    if ({1'b0, r_reg.div_cnt} >= div_of(r_reg.clksel) - 7'h01) begin
      r_next.div_cnt = '0;
      sys_tick = 1'b1;
    end else begin
      r_next.div_cnt = r_reg.div_cnt + 6'h01;
    end
    tad_tick = frc_sel ? frc_tick : (sys_tick & ~sleep_active);

    // apb: read data captured in setup, writes land in access
    setup = psel & ~penable;
    wr = psel & penable & pwrite & addr_ok(paddr);
    if (setup) begin
      case (paddr)
        OFF_CTRL0: r_next.rdata = {1'b0, r_reg.chan, r_reg.run, r_reg.enable};
        OFF_CTRL2: r_next.rdata = {5'h00, r_reg.trig};
        OFF_CFG: r_next.rdata = {4'h0, r_reg.ie, r_reg.clksel};
        OFF_STAT: r_next.rdata = {5'h00, ~r_reg.powered_down & r_reg.enable,
                                  r_reg.state != ACS_IDLE, r_reg.done};
        OFF_RESH: r_next.rdata = {6'h00, r_reg.result[RES_W-1:REG_W]};
        OFF_RESL: r_next.rdata = r_reg.result[REG_W-1:0];
        default: r_next.rdata = 8'h00;
      endcase
    end

    if (wr && paddr == OFF_CTRL0) begin
      r_next.chan = pwdata[CTRL0_CHS_LSB +: CHS_W];
      r_next.enable = pwdata[CTRL0_EN];
      if (!pwdata[CTRL0_EN]) begin
        kill = 1'b1;
      end else if (pwdata[CTRL0_RUN] && !r_reg.run) begin
        start_req = 1'b1;
      end else if (!pwdata[CTRL0_RUN] && r_reg.run) begin
        sw_abort = 1'b1;
      end
    end
    if (wr && paddr == OFF_CTRL2) begin
      r_next.trig = pwdata[CTRL2_TRIG_LSB +: TRIG_W];
    end
    if (wr && paddr == OFF_CFG) begin
      r_next.clksel = pwdata[CFG_CLK_LSB +: CLK_W];
      r_next.ie = pwdata[CFG_IE];
    end
    if (wr && paddr == OFF_STAT && pwdata[STAT_DONE]) begin
      r_next.done = 1'b0;
    end

    // automatic trigger on a rising edge of the selected source
    edges = r_reg.trg_s2 & ~r_reg.trg_s3;
    case (r_reg.trig)
      TRIG_TIMER_ZERO_EVENT: trig_edge = edges[0];
      TRIG_TIMER_ONE_EVENT: trig_edge = edges[1];
      TRIG_TIMER_TWO_EVENT: trig_edge = edges[2];
      TRIG_CMP1: trig_edge = edges[3];
      TRIG_CMP2: trig_edge = edges[4];
      default: trig_edge = 1'b0;
    endcase
    if (trig_edge && r_reg.enable && !r_reg.run && !kill) begin
      start_req = 1'b1;
    end

    // sleep on a system derived clock kills the conversion and the converter
    if (sleep_active && !frc_sel && r_reg.enable) begin
      r_next.powered_down = 1'b1;
      if (r_reg.run) begin
        kill = 1'b1;
      end
    end
    if (!sleep_active && r_reg.powered_down) begin
      r_next.powered_down = 1'b0;
    end
    if (sleep_active && !frc_sel) begin
      start_req = 1'b0;
    end

    case (r_reg.state)
      ACS_IDLE: begin
        if (start_req) begin
          r_next.run = 1'b1;
          r_next.powered_down = 1'b0;
          if (frc_sel) begin
            r_next.state = ACS_DELAY;
            r_next.delay_cnt = '0;
          end else begin
            r_next.state = ACS_CONV;
            start_pulse = 1'b1;
          end
        end
      end
      ACS_DELAY: begin
        if (kill || sw_abort) begin
          r_next.run = 1'b0;
          r_next.state = ACS_IDLE;
        end else if (r_reg.delay_cnt == 2'(INSTR_CYCLES - 1)) begin
          r_next.state = ACS_CONV;
          start_pulse = 1'b1;
        end else begin
          r_next.delay_cnt = r_reg.delay_cnt + 2'h1;
        end
      end
      ACS_CONV: begin
        if (sif.done) begin
          r_next.run = 1'b0;
          r_next.done = 1'b1;
          r_next.result = sif.result;
          r_next.state = ACS_IDLE;
          if (sleep_active && r_reg.ie) begin
            r_next.wake = 1'b1;
          end
          if (sleep_active && !r_reg.ie) begin
            r_next.powered_down = 1'b1;
          end
        end else if (kill) begin
          abort_pulse = 1'b1;
          r_next.run = 1'b0;
          r_next.state = ACS_IDLE;
        end else if (sw_abort) begin
          abort_pulse = 1'b1;
          r_next.run = 1'b0;
          r_next.result = sif.partial;
          r_next.state = ACS_IDLE;
        end
      end
      default: begin
        r_next.state = ACS_IDLE;
        r_next.run = 1'b0;
      end
    endcase
  end

  // asynchronous reset returns every register to its reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.state <= ACS_IDLE;
      r_reg.chan <= CTRL0_RST[CTRL0_CHS_LSB +: CHS_W];
      r_reg.trig <= TRIG_RST;
      r_reg.clksel <= CLK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sif.start = start_pulse;
  assign sif.abort = abort_pulse;
  assign sif.tad_tick = tad_tick;
  assign sif.cmp = r_reg.cmp_s2;

  acs_sar_engine u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif)
  );

  assign prdata = {24'h00_0000, r_reg.rdata};
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign converter_powered = r_reg.enable & ~r_reg.powered_down;
  assign sample_hold_en = converter_powered & (r_reg.state != ACS_CONV);
  assign channel_select = r_reg.chan;
  assign sar_dac_code = sif.dac_code;
  assign conversion_done_flag = r_reg.done;
  assign wake_request = r_reg.wake;
endmodule

/* File: acs_top_sva.sv */
// port checker for the converter sequencer, bound to its top
`timescale 1ns/1ns
module acs_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [acs_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acs_pkg::APB_DW-1:0] pwdata,
  input wire logic [acs_pkg::APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_active,
  input wire logic timer_zero_event,
  input wire logic timer_one_event,
  input wire logic timer_two_event,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  input wire logic frc_clock_in,
  input wire logic sar_comparator_in,
  input wire logic converter_powered,
  input wire logic sample_hold_en,
  input wire logic [acs_pkg::CHS_W-1:0] channel_select,
  input wire logic [acs_pkg::RES_W-1:0] sar_dac_code,
  input wire logic conversion_done_flag,
  input wire logic wake_request
);
  import acs_pkg::*;
  logic apb_wr;
  logic stat_clr;
  logic [2:0] clk_sel_reg;
  assign apb_wr = psel && penable && pwrite;
  assign stat_clr = apb_wr && paddr == OFF_STAT && pwdata[STAT_DONE];
  // conversion clock select as last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_reg <= CLK_RST;
    end else if (apb_wr && paddr == OFF_CFG) begin
      clk_sel_reg <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_ready_a: assert property (pready == (psel && penable))
    else $error("pready does not follow the access phase");
  ctrl0_bit7_a: assert property (psel && penable && !pwrite && paddr == OFF_CTRL0
    |-> prdata[31:7] == '0) else $error("control zero upper bits read nonzero");
  chan_follow_a: assert property (apb_wr && paddr == OFF_CTRL0
    |=> channel_select == $past(pwdata[6:2])) else $error("channel field not updated");
  done_power_a: assert property ($rose(conversion_done_flag)
    |-> $past(converter_powered, 2)) else $error("done without converter power");
  hold_power_a: assert property (sample_hold_en |-> converter_powered)
    else $error("sample and hold active while unpowered");
  done_keep_a: assert property (conversion_done_flag && !stat_clr
    |=> conversion_done_flag) else $error("done flag dropped without clear");
  done_clear_a: assert property ($fell(conversion_done_flag) |-> $past(stat_clr))
    else $error("done flag fell with no clear write");
  wake_pulse_a: assert property (wake_request |=> !wake_request)
    else $error("wake request longer than one cycle");
  wake_sleep_a: assert property (wake_request |-> $past(sleep_active))
    else $error("wake request outside sleep");
  sleep_off_a: assert property (sleep_active && clk_sel_reg[1:0] != 2'b11 ##1
    sleep_active |-> !converter_powered) else $error("powered in sleep on system clock");
  reset_clear_a: assert property ($rose(presetn)
    |-> !converter_powered && !conversion_done_flag && channel_select == '0)
    else $error("state not cleared by reset");

  cover property ($rose(conversion_done_flag));
  cover property (wake_request);
  cover property (sleep_active && !converter_powered);
endmodule

bind acs_top acs_top_sva u_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_active(sleep_active), .timer_zero_event(timer_zero_event),
  .timer_one_event(timer_one_event), .timer_two_event(timer_two_event),
  .comparator_one_output(comparator_one_output), .frc_clock_in(frc_clock_in),
  .comparator_two_output(comparator_two_output), .sar_comparator_in(sar_comparator_in),
  .converter_powered(converter_powered), .sample_hold_en(sample_hold_en),
  .channel_select(channel_select), .sar_dac_code(sar_dac_code),
  .conversion_done_flag(conversion_done_flag), .wake_request(wake_request));

/* File: adc_conversion_sequencer_tb_top.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
module adc_conversion_sequencer_tb_top;
  import acs_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m; logic x; string n;} acs_note_t;
  logic pclk, presetn, psel, penable, pwrite, sleep_active, frc, woke, ok;
  logic pready, pslverr, powered, shold, done, wake, cmp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0] trg, chan;
  logic [9:0] dac, vin, r, e;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  acs_note_t q[$];
  acs_note_t nt;

  acs_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_active(sleep_active), .timer_zero_event(trg[0]), .timer_one_event(trg[1]),
    .timer_two_event(trg[2]), .comparator_one_output(trg[3]), .comparator_two_output(trg[4]),
    .frc_clock_in(frc), .sar_comparator_in(cmp), .converter_powered(powered),
    .sample_hold_en(shold), .channel_select(chan), .sar_dac_code(dac),
    .conversion_done_flag(done), .wake_request(wake));

  // analog input model: keep trial bit while input is not below it
  assign cmp = dac <= vin;
  always #25 pclk = ~pclk;
  initial begin
    frc = 1'b0;
    #37;
    forever #160 frc = ~frc;
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (wake === 1'b1) woke <= 1'b1;
    if (presetn && psel && penable && !pwrite && q.size() > 0) begin
      nt = q.pop_front();
      chk(nt.n, prdata & nt.m, nt.e);
      chk("pslverr", pslverr, nt.x);
    end
    if (cyc == 40000) begin
      errors++;
      tally_and_finish;
    end
  end

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic x,
    input string n);
    q.push_back('{e, m, x, n});
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  // how: 0 software start, else trigger source code
  task automatic conv(input int how, input logic [2:0] cs, input logic ie, input logic slp);
    vin = 10'($urandom);
    woke = 1'b0;
    wr(OFF_CFG, 32'({ie, cs}));
    wr(OFF_CTRL2, 32'(how));
    wr(OFF_CTRL0, 32'h0000_0015);
    repeat (20) @(posedge pclk);
    if (how == 0) begin
      wr(OFF_CTRL0, 32'h0000_0017);
      if (slp) sleep_active <= 1'b1;
      @(posedge pclk);
      #1 chk("hold", shold, cs[1:0] == 2'b11);
    end else begin
      trg[how-1] <= 1'b1;
      repeat (4) @(posedge pclk);
      trg <= 5'h00;
    end
    repeat (3000) if (done !== 1'b1) @(posedge pclk);
    repeat (2) @(posedge pclk);
    #1 chk("done", done, 1'b1);
    chk("dac", dac, vin);
    if (slp) begin
      chk("woke", woke, ie);
      chk("power", powered, ie);
    end
    sleep_active <= 1'b0;
    rd(OFF_CTRL0, 32'h0000_0015, 32'hffff_ffff, 1'b0, "ctrl0");
    rd(OFF_RESH, 32'(vin[9:8]), 32'hffff_ffff, 1'b0, "resh");
    rd(OFF_RESL, 32'(vin[7:0]), 32'hffff_ffff, 1'b0, "resl");
    wr(OFF_STAT, 32'h0000_0001);
    @(posedge pclk);
    #1 chk("clear", done, 1'b0);
    $display("test conversion %0d done", how);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sleep_active = 1'b0;
    trg = 5'h00;
    vin = 10'h000;
    woke = 1'b0;
    void'($urandom(32'ha949_091c));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wr(12'h018, 32'h0000_00ff);
    for (int a = 0; a < 28; a += 4) rd(12'(a), 0, 32'hffff_ffff, a == 24, "reset");
    wr(OFF_CTRL0, 32'h0000_00fc);
    rd(OFF_CTRL0, 32'h0000_007c, 32'hffff_ffff, 1'b0, "bits");
    #1 chk("chan", chan, 5'h1f);
    wr(OFF_CTRL0, 32'h0000_0002);
    repeat (800) @(posedge pclk);
    rd(OFF_CTRL0, 32'h0000_0000, 32'hffff_ffff, 1'b0, "norun");
    #1 chk("idle", done, 1'b0);
    $display("test registers done");
    conv(0, 3'h6, 1'b0, 1'b0);
    conv(0, 3'h3, 1'b1, 1'b1);
    conv(0, 3'h7, 1'b0, 1'b1);
    for (int k = 1; k < 6; k++) conv(k, 3'h6, 1'b0, 1'b0);
    for (int k = 0; k < 8; k += 6) begin
      wr(OFF_CTRL2, 32'(k));
      trg <= 5'h1f;
      repeat (4) @(posedge pclk);
      trg <= 5'h00;
      repeat (20) @(posedge pclk);
      rd(OFF_CTRL0, 32'h0000_0015, 32'hffff_ffff, 1'b0, "notrig");
    end
    vin = 10'($urandom);
    wr(OFF_CTRL0, 32'h0000_0017);
    repeat (300) @(posedge pclk);
    wr(OFF_CTRL0, 32'h0000_0015);
    repeat (4) @(posedge pclk);
    rd(OFF_RESH, 0, 0, 1'b0, "resh");
    r[9:8] = rdat[1:0];
    rd(OFF_RESL, 0, 0, 1'b0, "resl");
    r[7:0] = rdat[7:0];
    ok = 1'b0;
    for (int k = 0; k <= 10; k++) begin
      e = vin;
      for (int i = 0; i < 10 - k; i++) e[i] = (k == 0) ? 1'b0 : vin[10-k];
      if (r === e) ok = 1'b1;
    end
    chk("partial", ok, 1'b1);
    $display("test abort done");
    wr(OFF_CTRL0, 32'h0000_0017);
    repeat (100) @(posedge pclk);
    sleep_active <= 1'b1;
    repeat (3) @(posedge pclk);
    #1 chk("sleepoff", powered, 1'b0);
    sleep_active <= 1'b0;
    rd(OFF_CTRL0, 32'h0000_0015, 32'hffff_ffff, 1'b0, "sleepctl");
    repeat (900) @(posedge pclk);
    #1 chk("nodone", done, 1'b0);
    $display("test sleep abort done");
    wr(OFF_CTRL0, 32'h0000_0017);
    repeat (100) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    #1 chk("rstpower", powered, 1'b0);
    presetn <= 1'b1;
    rd(OFF_CTRL0, 32'h0000_0000, 32'hffff_ffff, 1'b0, "rstctl");
    rd(OFF_RESL, 32'h0000_0000, 32'hffff_ffff, 1'b0, "rstres");
    $display("test midrun reset done");
    tally_and_finish;
  end
endmodule
